// file: qba_datapath.sv
// combinational byte alignment and lane averaging
`timescale 1ns/100ps
module qba_datapath
	import qba_pkg::*;
(
	qba_op_if.dp op
);
	// bytes k..k+3 of the eight byte pair, lower register in the low half
	function automatic logic [31:0] qba_align(
		input logic [31:0] lo,
		input logic [31:0] hi,
		input logic [1:0] k
	);
		logic [63:0] pair;
		pair = {hi, lo};
		return pair[8*k +: 32];
	endfunction

	logic [31:0] y;
	logic [31:0] z;
	logic [1:0] kb;
	logic rnd;
	logic [31:0] avg_byte;
	logic [31:0] avg_half;

	// half-word form shares the first index for both pairs
	assign kb = (op.op == QBA_OP_HALF) ? op.idx_a : op.idx_b;
	// reverse swaps the registers before the byte selection
	assign y = op.reverse ? qba_align(op.src_a_hi, op.src_a_lo, op.idx_a)
		: qba_align(op.src_a_lo, op.src_a_hi, op.idx_a);
	assign z = op.reverse ? qba_align(op.src_b_hi, op.src_b_lo, kb)
		: qba_align(op.src_b_lo, op.src_b_hi, kb);
	// rounding follows only the instruction option
	assign rnd = ~op.truncate;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_byte
			logic [8:0] s9;
			// nine bit sum keeps the carry
			assign s9 = {1'b0, y[8*i +: 8]} + {1'b0, z[8*i +: 8]} + {8'h00, rnd};
			assign avg_byte[8*i +: 8] = s9[8:1];
		end
		for (i = 0; i < 2; i++) begin : g_half
			logic [9:0] s10;
			logic [7:0] m;
			assign s10 = {2'b00, y[16*i +: 8]} + {2'b00, y[16*i+8 +: 8]}
				+ {2'b00, z[16*i +: 8]} + {2'b00, z[16*i+8 +: 8]}
				+ {8'h00, rnd, 1'b0};
			assign m = s10[9:2];
			// unused byte of each half-word is zero
			assign avg_half[16*i +: 16] = op.into_high ? {m, 8'h00}
				: {8'h00, m};
		end
	endgenerate

	assign op.result = (op.op == QBA_OP_HALF) ? avg_half : avg_byte;
endmodule // qba_datapath

// file: qba_host_model.sv
// bus master standing in for the decoder and data register file
`timescale 1ns/100ps
module qba_host_model
	import qba_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	output logic bus_cyc,
	output logic bus_stb,
	output logic bus_we,
	output logic [QBA_AW-1:0] bus_adr,
	output logic [3:0] bus_sel,
	output logic [31:0] bus_dat
);
	initial begin
		bus_cyc = 1'b0;
		bus_stb = 1'b0;
		bus_we = 1'b0;
		bus_adr = 8'h00;
		bus_sel = 4'h0;
		bus_dat = 32'h0000_0000;
	end

	// entered just after a rising edge; ack is read before that edge's updates land
	task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		input logic [3:0] sel, output logic [31:0] rd);
		bus_cyc <= 1'b1;
		bus_stb <= 1'b1;
		bus_we <= we;
		bus_adr <= adr;
		bus_sel <= sel;
		bus_dat <= dat;
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		bus_cyc <= 1'b0;
		bus_stb <= 1'b0;
		// idle cycle so a repeat call never meets the dropping ack
		@(posedge clk_sys);
	endtask
endmodule // qba_host_model

// file: qba_op_if.sv
// operand and result bundle between the control and the datapath
`timescale 1ns/100ps
interface qba_op_if;
	logic [31:0] src_a_lo;
	logic [31:0] src_a_hi;
	logic [31:0] src_b_lo;
	logic [31:0] src_b_hi;
	logic [1:0] idx_a;
	logic [1:0] idx_b;
	qba_pkg::qba_op_e op;
	logic truncate;
	logic reverse;
	logic into_high;
	logic [31:0] result;
	modport ctl (
		output src_a_lo, src_a_hi, src_b_lo, src_b_hi,
		output idx_a, idx_b, op, truncate, reverse, into_high,
		input result
	);
	modport dp (
		input src_a_lo, src_a_hi, src_b_lo, src_b_hi,
		input idx_a, idx_b, op, truncate, reverse, into_high,
		output result
	);
endinterface // qba_op_if

// file: qba_pkg.sv
// constants and types shared by the quad byte average unit
package qba_pkg;
	localparam int QBA_AW = 8;
	localparam logic [7:0] QBA_ADR_CTRL = 8'h00;
	localparam logic [7:0] QBA_ADR_IDX0 = 8'h04;
	localparam logic [7:0] QBA_ADR_IDX1 = 8'h08;
	localparam logic [7:0] QBA_ADR_A_LO = 8'h0C;
	localparam logic [7:0] QBA_ADR_A_HI = 8'h10;
	localparam logic [7:0] QBA_ADR_B_LO = 8'h14;
	localparam logic [7:0] QBA_ADR_B_HI = 8'h18;
	localparam logic [7:0] QBA_ADR_ARITHMETIC_STATUS_REGISTER = 8'h1C;
	localparam logic [7:0] QBA_ADR_RESULT = 8'h20;
	localparam logic [7:0] QBA_ADR_STATUS = 8'h24;
	// control register bit positions
	localparam int QBA_CTL_START = 0;
	localparam int QBA_CTL_HALF = 1;
	localparam int QBA_CTL_TRUNC = 2;
	localparam int QBA_CTL_REV = 3;
	localparam int QBA_CTL_HIGH = 4;
	localparam int QBA_CTL_LONG = 5;
	// status register bit positions
	localparam int QBA_ST_DONE = 0;
	localparam int QBA_ST_ILLEGAL = 1;
	localparam int QBA_ST_MISALIGN = 2;
	// arithmetic status bit position of the rounding mode
	localparam int QBA_ARITHMETIC_STATUS_REGISTER_RND = 8;
	localparam logic [31:0] QBA_WORD_RST = 32'h0000_0000;
	localparam logic [31:0] QBA_UNMAPPED = 32'h0000_0000;
	localparam logic QBA_LONG_RST = 1'b1;
	typedef enum logic [1:0] {
		QBA_OP_BYTE = 2'b01,
		QBA_OP_HALF = 2'b10
	} qba_op_e;
endpackage

// file: qba_unit.sv
// quad byte average unit with a classic wishbone register slave
// Behaviour
// - byte average puts each lane's mean in the matching result byte.
// - each lane mean is the two byte sum shifted right once.
// - without truncation an odd sum is rounded up by adding one.
// - truncation drops the shifted out bit; reverse may be added.
// - the global rounding mode bit never affects these averages.
// - first pair alignment comes from first index low two bits.
// - second pair alignment comes from second index low two bits.
// - alignment k picks bytes k to k+3 of the eight byte pair.
// - by default the lower register gives the low-order bytes.
// - reverse swaps the registers within each pair before alignment.
// - alignment is internal, so no misaligned exception is ever raised.
// - both averages are accepted only in the long encoding.
// - half-word rounding variants place results in low or high bytes.
// - half-word truncating variants place results in low or high bytes.
// - half-word mean sums four bytes and shifts right two places.
// - the unused byte of each result half-word is zero.
// - half-word form uses the first index for both pairs.
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module qba_unit
	import qba_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [QBA_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [31:0] idx0;
		logic [31:0] idx1;
		logic [31:0] a_lo;
		logic [31:0] a_hi;
		logic [31:0] b_lo;
		logic [31:0] b_hi;
		logic [31:0] arithmetic_status_register;
		logic half;
		logic trunc;
		logic rev;
		logic high;
		logic long_enc;
		logic go;
		logic [31:0] result;
		logic done;
		logic illegal;
	} qba_state_s;

	qba_state_s st_reg;
	qba_state_s st_next;
	qba_op_if opi ();
	logic wr;
	logic [31:0] ctrl_rd;
	logic [31:0] stat_rd;

	// word decode, shared by read and write paths
	function automatic logic qba_hit(
		input logic [QBA_AW-1:0] adr,
		input logic [7:0] ofs
	);
		return adr[QBA_AW-1:2] == ofs[QBA_AW-1:2];
	endfunction

	// byte lane merge for partial writes
	function automatic logic [31:0] qba_merge(
		input logic [31:0] old,
		input logic [31:0] dat,
		input logic [3:0] sel
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign ctrl_rd = {26'h0, st_reg.long_enc, st_reg.high, st_reg.rev,
		st_reg.trunc, st_reg.half, 1'b0};
	// misaligned flag is wired low: alignment never leaves the registers
	assign stat_rd = {29'h0, 1'b0, st_reg.illegal, st_reg.done};
	// the write lands at the edge where the master sees ack
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & st_reg.ack;

	always_comb begin
		st_next = st_reg;
		st_next.go = 1'b0;
		st_next.ack = wb_cyc_i & wb_stb_i & ~st_reg.ack;
		if (st_next.ack) begin
			if (qba_hit(wb_adr_i, QBA_ADR_CTRL)) begin
				st_next.rdat = ctrl_rd;
			end else if (qba_hit(wb_adr_i, QBA_ADR_IDX0)) begin
				st_next.rdat = st_reg.idx0;
			end else if (qba_hit(wb_adr_i, QBA_ADR_IDX1)) begin
				st_next.rdat = st_reg.idx1;
			end else if (qba_hit(wb_adr_i, QBA_ADR_A_LO)) begin
				st_next.rdat = st_reg.a_lo;
			end else if (qba_hit(wb_adr_i, QBA_ADR_A_HI)) begin
				st_next.rdat = st_reg.a_hi;
			end else if (qba_hit(wb_adr_i, QBA_ADR_B_LO)) begin
				st_next.rdat = st_reg.b_lo;
			end else if (qba_hit(wb_adr_i, QBA_ADR_B_HI)) begin
				st_next.rdat = st_reg.b_hi;
			end else if (qba_hit(wb_adr_i, QBA_ADR_ARITHMETIC_STATUS_REGISTER)) begin
				st_next.rdat = st_reg.arithmetic_status_register;
			end else if (qba_hit(wb_adr_i, QBA_ADR_RESULT)) begin
				st_next.rdat = st_reg.result;
			end else if (qba_hit(wb_adr_i, QBA_ADR_STATUS)) begin
				st_next.rdat = stat_rd;
			end else begin
				st_next.rdat = QBA_UNMAPPED;
			end
		end
		if (wr) begin
			if (qba_hit(wb_adr_i, QBA_ADR_CTRL)) begin
				if (wb_sel_i[0]) begin
					st_next.half = wb_dat_i[QBA_CTL_HALF];
					st_next.trunc = wb_dat_i[QBA_CTL_TRUNC];
					st_next.rev = wb_dat_i[QBA_CTL_REV];
					st_next.high = wb_dat_i[QBA_CTL_HIGH];
					st_next.long_enc = wb_dat_i[QBA_CTL_LONG];
					st_next.go = wb_dat_i[QBA_CTL_START];
					if (wb_dat_i[QBA_CTL_START]) begin
						st_next.done = 1'b0;
						st_next.illegal = 1'b0;
					end
				end
			end else if (qba_hit(wb_adr_i, QBA_ADR_IDX0)) begin
				st_next.idx0 = qba_merge(st_reg.idx0, wb_dat_i, wb_sel_i);
			end else if (qba_hit(wb_adr_i, QBA_ADR_IDX1)) begin
				st_next.idx1 = qba_merge(st_reg.idx1, wb_dat_i, wb_sel_i);
			end else if (qba_hit(wb_adr_i, QBA_ADR_A_LO)) begin
				st_next.a_lo = qba_merge(st_reg.a_lo, wb_dat_i, wb_sel_i);
			end else if (qba_hit(wb_adr_i, QBA_ADR_A_HI)) begin
				st_next.a_hi = qba_merge(st_reg.a_hi, wb_dat_i, wb_sel_i);
			end else if (qba_hit(wb_adr_i, QBA_ADR_B_LO)) begin
				st_next.b_lo = qba_merge(st_reg.b_lo, wb_dat_i, wb_sel_i);
			end else if (qba_hit(wb_adr_i, QBA_ADR_B_HI)) begin
				st_next.b_hi = qba_merge(st_reg.b_hi, wb_dat_i, wb_sel_i);
			end else if (qba_hit(wb_adr_i, QBA_ADR_ARITHMETIC_STATUS_REGISTER)) begin
				// stored for software only, never fed to the datapath
				st_next.arithmetic_status_register = qba_merge(st_reg.arithmetic_status_register, wb_dat_i, wb_sel_i);
			end
		end
		// completion after any clear, so a set in the same cycle wins
		if (st_reg.go) begin
			if (st_reg.long_enc) begin
				st_next.result = opi.result;
				st_next.done = 1'b1;
			end else begin
				// short encoding has no averaging form
				st_next.illegal = 1'b1;
				st_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= '{ack: 1'b0, rdat: QBA_WORD_RST, idx0: QBA_WORD_RST,
				idx1: QBA_WORD_RST, a_lo: QBA_WORD_RST, a_hi: QBA_WORD_RST,
				b_lo: QBA_WORD_RST, b_hi: QBA_WORD_RST, arithmetic_status_register: QBA_WORD_RST,
				half: 1'b0, trunc: 1'b0, rev: 1'b0, high: 1'b0,
				long_enc: QBA_LONG_RST, go: 1'b0, result: QBA_WORD_RST,
				done: 1'b0, illegal: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// operands are always the fixed pairs one:zero and three:two
	assign opi.src_a_lo = st_reg.a_lo;
	assign opi.src_a_hi = st_reg.a_hi;
	assign opi.src_b_lo = st_reg.b_lo;
	assign opi.src_b_hi = st_reg.b_hi;
	assign opi.idx_a = st_reg.idx0[1:0];
	assign opi.idx_b = st_reg.idx1[1:0];
	assign opi.op = st_reg.half ? QBA_OP_HALF : QBA_OP_BYTE;
	assign opi.truncate = st_reg.trunc;
	assign opi.reverse = st_reg.rev;
	assign opi.into_high = st_reg.high;

	qba_datapath u_dp (
		.op(opi)
	);

	assign wb_dat_o = st_reg.rdat;
	assign wb_ack_o = st_reg.ack;

	// reference sums for the checks below
	logic [8:0] chk_l0;
	logic [8:0] chk_l3;
	logic [8:0] chk_al1;
	logic [8:0] chk_bl3;
	logic [8:0] chk_rev;
	logic [9:0] chk_h0;
	logic byte_go;
	logic idx_zero;
	logic [8:0] chk_o3;
	logic [9:0] chk_h1;
	assign chk_l0 = {1'b0, st_reg.a_lo[7:0]} + {1'b0, st_reg.b_lo[7:0]};
	assign chk_l3 = {1'b0, st_reg.a_lo[31:24]} + {1'b0, st_reg.b_lo[31:24]};
	assign chk_al1 = {1'b0, st_reg.a_lo[15:8]} + {1'b0, st_reg.b_lo[7:0]};
	assign chk_bl3 = {1'b0, st_reg.a_lo[7:0]} + {1'b0, st_reg.b_lo[31:24]};
	assign chk_rev = {1'b0, st_reg.a_hi[7:0]} + {1'b0, st_reg.b_hi[7:0]};
	assign chk_h0 = {2'b00, st_reg.a_lo[7:0]} + {2'b00, st_reg.a_lo[15:8]}
		+ {2'b00, st_reg.b_lo[7:0]} + {2'b00, st_reg.b_lo[15:8]};
	assign byte_go = st_reg.go & st_reg.long_enc & ~st_reg.half;
	assign idx_zero = (st_reg.idx0[1:0] == 2'b00) & (st_reg.idx1[1:0] == 2'b00);
	// window one: byte four comes from the higher register
	assign chk_o3 = {1'b0, st_reg.a_hi[7:0]} + {1'b0, st_reg.b_lo[31:24]};
	assign chk_h1 = {2'b00, st_reg.a_lo[15:8]} + {2'b00, st_reg.a_lo[23:16]}
		+ {2'b00, st_reg.b_lo[15:8]} + {2'b00, st_reg.b_lo[23:16]};

	AST_ROUND_UP: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & ~st_reg.trunc & ~st_reg.rev & idx_zero
		|=> st_reg.result[7:0] == $past(8'((chk_l0 + 9'h001) >> 1))
			&& st_reg.done)
		else $error("byte average did not round up lane 0");

	AST_TRUNCATE: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & st_reg.trunc & ~st_reg.rev & idx_zero
		|=> st_reg.result[31:24] == $past(chk_l3[8:1]))
		else $error("truncated lane 3 average wrong");

	AST_MODE_IGNORED: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & ~st_reg.trunc & ~st_reg.rev & idx_zero
			& st_reg.arithmetic_status_register[QBA_ARITHMETIC_STATUS_REGISTER_RND]
		|=> st_reg.result[31:24] == $past(8'((chk_l3 + 9'h001) >> 1)))
		else $error("rounding mode bit changed the average");

	AST_ALIGN_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & st_reg.trunc & ~st_reg.rev
			& (st_reg.idx0[1:0] == 2'b01) & (st_reg.idx1[1:0] == 2'b00)
		|=> st_reg.result[7:0] == $past(chk_al1[8:1]))
		else $error("first pair alignment wrong");

	AST_ALIGN_SECOND: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & st_reg.trunc & ~st_reg.rev
			& (st_reg.idx0[1:0] == 2'b00) & (st_reg.idx1[1:0] == 2'b11)
		|=> st_reg.result[7:0] == $past(chk_bl3[8:1]))
		else $error("second pair alignment wrong");

	AST_REVERSE: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & st_reg.trunc & st_reg.rev & idx_zero
		|=> st_reg.result[7:0] == $past(chk_rev[8:1]))
		else $error("reverse order did not take the high register");

	AST_HALF_MEAN: assert property (@(posedge clk_sys) disable iff (rst)
		st_reg.go & st_reg.long_enc & st_reg.half & st_reg.trunc
			& ~st_reg.rev & ~st_reg.high & (st_reg.idx0[1:0] == 2'b00)
		|=> st_reg.result[15:0] == {8'h00, $past(chk_h0[9:2])})
		else $error("half-word mean of four bytes wrong");

	AST_HALF_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
		st_reg.go & st_reg.long_enc & st_reg.half
		|=> (st_reg.high ? (st_reg.result[23:16] == 8'h00)
			&& (st_reg.result[7:0] == 8'h00)
			: (st_reg.result[31:24] == 8'h00)
			&& (st_reg.result[15:8] == 8'h00)))
		else $error("unused half-word byte not zero");

	AST_SHORT_REFUSED: assert property (@(posedge clk_sys) disable iff (rst)
		st_reg.go & ~st_reg.long_enc
		|=> st_reg.illegal && $stable(st_reg.result))
		else $error("short encoding produced a result");

	AST_HALF_ROUND: assert property (@(posedge clk_sys) disable iff (rst)
		st_reg.go & st_reg.long_enc & st_reg.half & ~st_reg.trunc
			& ~st_reg.rev & ~st_reg.high & (st_reg.idx0[1:0] == 2'b00)
		|=> st_reg.result[15:0] == {8'h00, $past(8'((chk_h0 + 10'h002) >> 2))})
		else $error("rounded half-word mean wrong");

	AST_HALF_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
		st_reg.go & st_reg.long_enc & st_reg.half & st_reg.trunc
			& ~st_reg.rev & st_reg.high & (st_reg.idx0[1:0] == 2'b00)
		|=> st_reg.result[15:0] == {$past(chk_h0[9:2]), 8'h00})
		else $error("truncated half-word mean not in high byte");

	AST_HALF_INDEX: assert property (@(posedge clk_sys) disable iff (rst)
		st_reg.go & st_reg.long_enc & st_reg.half & st_reg.trunc & ~st_reg.rev
			& ~st_reg.high & (st_reg.idx0[1:0] == 2'b01) & (st_reg.idx1[1:0] == 2'b00)
		|=> st_reg.result[15:0] == {8'h00, $past(chk_h1[9:2])})
		else $error("half-word form did not use the first index for both pairs");

	AST_PAIR_ORDER: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & st_reg.trunc & ~st_reg.rev
			& (st_reg.idx0[1:0] == 2'b01) & (st_reg.idx1[1:0] == 2'b00)
		|=> st_reg.result[31:24] == $past(chk_o3[8:1]))
		else $error("default pair order wrong in lane 3");

	AST_ROUND_REV: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & ~st_reg.trunc & st_reg.rev & idx_zero
		|=> st_reg.result[7:0] == $past(8'((chk_rev + 9'h001) >> 1)))
		else $error("rounded reverse average wrong in lane 0");

	AST_WIDE_SUM: assert property (@(posedge clk_sys) disable iff (rst)
		byte_go & ~st_reg.rev & idx_zero & chk_l0[8]
		|=> st_reg.result[7] == 1'b1)
		else $error("lane 0 carry lost before the shift");
endmodule // qba_unit

// file: qba_unit_tb.sv
// self-checking bench for the quad byte average unit
`timescale 1ns/100ps
module qba_unit_tb;
	import qba_pkg::*;
	logic clk_sys, rst, wb_ack_o, bus_cyc, bus_stb, bus_we;
	logic [31:0] wb_dat_o, bus_dat, got, exp_res;
	logic [7:0] bus_adr;
	logic [3:0] bus_sel;
	logic half, trunc, rev, high;
	logic [2:0] v;
	logic [31:0] opr [4] = '{32'hFF01_7F80, 32'h0203_FEFF, 32'h01FF_8081, 32'hFD04_FF00};
	int fails, n_compared, cycles;

	qba_unit uut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(bus_cyc), .wb_stb_i(bus_stb),
		.wb_we_i(bus_we), .wb_adr_i(bus_adr), .wb_sel_i(bus_sel), .wb_dat_i(bus_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	qba_host_model host (.clk_sys(clk_sys), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.bus_cyc(bus_cyc), .bus_stb(bus_stb), .bus_we(bus_we), .bus_adr(bus_adr),
		.bus_sel(bus_sel), .bus_dat(bus_dat));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic finish_test;
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ceiling about six times the planned run
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			finish_test;
		end
	end

	task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_compared++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] unused;
		host.access(1'b1, adr, dat, 4'hF, unused);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] seen;
		host.access(1'b0, adr, 32'h0000_0000, 4'hF, seen);
		check32(name, exp, seen);
	endtask

	// independent lane model: pair swap, window select, wide sums
	function automatic logic [31:0] ref_avg(input logic [1:0] ia, input logic [1:0] ib,
		input logic hw, input logic tr, input logic rv, input logic hi);
		logic [63:0] pa, pb;
		logic [31:0] y, z, r;
		logic [9:0] s;
		pa = rv ? {opr[0], opr[1]} : {opr[1], opr[0]};
		pb = rv ? {opr[2], opr[3]} : {opr[3], opr[2]};
		y = 32'(pa >> (8 * ia));
		z = 32'(pb >> (8 * (hw ? ia : ib)));
		r = 32'h0000_0000;
		for (int i = 0; i < 4 && !hw; i++) begin
			s = 10'(y[8*i+:8]) + 10'(z[8*i+:8]) + 10'(!tr);
			r[8*i+:8] = s[8:1];
		end
		for (int h = 0; h < 2 && hw; h++) begin
			s = 10'(y[16*h+:8]) + 10'(y[16*h+8+:8]) + 10'(z[16*h+:8]) + 10'(z[16*h+8+:8]);
			s = s + (tr ? 10'h000 : 10'h002);
			r[16*h+8*int'(hi)+:8] = s[9:2];
		end
		return r;
	endfunction

	initial begin
		rst = 1'b1;
		fails = 0;
		n_compared = 0;
		cycles = 0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd_chk("ctrl reset", QBA_ADR_CTRL, 32'h0000_0020);
		rd_chk("result reset", QBA_ADR_RESULT, QBA_WORD_RST);
		rd_chk("status reset", QBA_ADR_STATUS, 32'h0000_0000);
		rd_chk("unmapped", 8'h40, QBA_UNMAPPED);
		check32("ack dropped", 32'h0000_0000, {31'h0, wb_ack_o});
		// operands only ever sit in pairs one:zero and three:two
		for (int i = 0; i < 4; i++) wr(QBA_ADR_A_LO + 8'(4 * i), opr[i]);
		host.access(1'b1, QBA_ADR_B_HI, 32'hAAAA_AAAA, 4'b0110, got);
		opr[3] = 32'hFDAA_AA00;
		rd_chk("byte lane write", QBA_ADR_B_HI, opr[3]);
		for (int ia = 0; ia < 4; ia++) begin
			for (int ib = 0; ib < 4; ib++) begin
				for (int m = 0; m < 12; m++) begin
					half = (m >= 4);
					v = 3'(half ? m - 4 : m);
					trunc = v[0];
					rev = v[1];
					high = half & v[2];
					// upper index bits are junk on purpose
					wr(QBA_ADR_IDX0, {30'(3 * m + 5), 2'(ia)});
					wr(QBA_ADR_IDX1, {30'(m + 1), 2'(ib)});
					// mode bit set under rounding and truncating variants alike
					wr(QBA_ADR_ARITHMETIC_STATUS_REGISTER, 32'(m % 3 == 0) << QBA_ARITHMETIC_STATUS_REGISTER_RND);
					wr(QBA_ADR_CTRL, {26'h0, 1'b1, high, rev, trunc, half, 1'b1});
					exp_res = ref_avg(2'(ia), 2'(ib), half, trunc, rev, high);
					rd_chk("result", QBA_ADR_RESULT, exp_res);
					rd_chk("status", QBA_ADR_STATUS, 32'h0000_0001);
				end
			end
		end
		wr(QBA_ADR_RESULT, 32'h5A5A_5A5A);
		rd_chk("result read only", QBA_ADR_RESULT, exp_res);
		// short encoding refused, result left alone
		wr(QBA_ADR_CTRL, 32'h0000_0001);
		rd_chk("short result", QBA_ADR_RESULT, exp_res);
		rd_chk("short status", QBA_ADR_STATUS, 32'h0000_0003);
		wr(QBA_ADR_CTRL, 32'h0000_0021);
		rd_chk("long result", QBA_ADR_RESULT, ref_avg(2'd3, 2'd3, 1'b0, 1'b0, 1'b0, 1'b0));
		rd_chk("long status", QBA_ADR_STATUS, 32'h0000_0001);
		finish_test;
	end
endmodule // qba_unit_tb
